// ===== general_purpose_timer_bank.v
// Functional notes
// - Six timers: five 32-bit counters and one 64-bit counter.
// - Four modes per timer: single-shot, repeating, keep-going, wrap without interrupt.
// - Each timer counts on slow real-time clock or system clock, chosen per timer.
// - Single-shot: on match raise interrupt, hold count, clear run enable.
// - Repeating: on match raise interrupt, count returns to zero, keeps counting.
// - Keep-going and wrap modes wrap only on overflow; only keep-going interrupts on match.
// - Only single-shot stops itself; others run until software disables them.
// - Divider ratio one through thirteen, or sixteen, thirty-two, sixty-four.
// - Every timer is configured and runs independently of the others.
// - Any unmasked timer interrupt also drives a wakeup request to sleep control.
// - Lower-word read captures upper word for next read; counting never pauses.
// - Current count readable at any time on either clock source.
// - Match writable anytime; writing while counting restarts count from zero.
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "gpt_bank_regs.vh"

module general_purpose_timer_bank (
   input wire mclk,
   input wire arst_n,
   input wire rtcClk,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg [5:0] timerIrq,
   output reg irq,
   output reg wakeReq
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Timer slot and register kind of a byte address
   function [2:0] slotOf;
      input [7:0] addr;
      begin
         slotOf = addr[`ADDR_SLOT_MSB:`TIMER_STRIDE_LSB];
      end
   endfunction

   function [2:0] kindOf;
      input [7:0] addr;
      begin
         kindOf = addr[`ADDR_KIND_MSB:`ADDR_KIND_LSB];
      end
   endfunction

   // Unaligned accesses are refused
   function isAligned;
      input [7:0] addr;
      begin
         isAligned = (addr[`ADDR_ALIGN_MSB:0] == 2'h0);
      end
   endfunction

   function mapped;
      input [7:0] addr;
      reg [2:0] idx;
      reg [2:0] kind;
      begin
         idx = slotOf(addr);
         kind = kindOf(addr);
         if (!isAligned(addr)) begin
            mapped = 1'b0;
         end else if (addr == `ADDR_IRQ_STATUS || addr == `ADDR_IRQ_MASK) begin
            mapped = 1'b1;
         end else if (idx > `LAST_TIMER) begin
            mapped = 1'b0;
         end else if (idx == `WIDE_INDEX) begin
            mapped = (kind <= `KIND_MATCH_HI);
         end else begin
            mapped = (kind <= `KIND_MATCH_LO);
         end
      end
   endfunction

   function [31:0] applyStrobe;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer b;
      begin
         applyStrobe = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               applyStrobe[b*8 +: 8] = data[b*8 +: 8];
            end
         end
      end
   endfunction

   function [6:0] divRatio;
      input [3:0] code;
      begin
         if (code <= `DIV_FINE_LAST) begin
            divRatio = {3'h0, code} + 7'h01;
         end else if (code == `DIV_CODE_16) begin
            divRatio = `RATIO_16;
         end else if (code == `DIV_CODE_32) begin
            divRatio = `RATIO_32;
         end else begin
            divRatio = `RATIO_64;
         end
      end
   endfunction

   // ----------------------------------------
   // Clock enables
   // ----------------------------------------
   reg rtcMeta;
   reg rtcSync;
   reg rtcPrev;
   reg [6:0] sysAcc;
   // A pin idling high after reset gives one early tick
   wire rtcTick = rtcSync & ~rtcPrev;
   wire [6:0] sysSum = sysAcc + `SYS_TICK_MHZ;
   wire sysTick = (sysSum >= `MCLK_MHZ);

   // Fractional accumulator: 13 ticks per 100 mclk cycles, jitter of one cycle
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rtcMeta <= 1'b0;
         rtcSync <= 1'b0;
         rtcPrev <= 1'b0;
         sysAcc <= 7'h00;
      end else begin
         rtcMeta <= rtcClk;
         rtcSync <= rtcMeta;
         rtcPrev <= rtcSync;
         sysAcc <= sysTick ? (sysSum - `MCLK_MHZ) : sysSum;
      end
   end

   // ----------------------------------------
   // Bus write and read decode
   // ----------------------------------------
   wire wrFire = s_axi_awready;
   wire wrHit = wrFire && mapped(s_axi_awaddr);
   wire [2:0] wrIdx = slotOf(s_axi_awaddr);
   wire [2:0] wrKind = kindOf(s_axi_awaddr);
   wire rdFire = s_axi_arready;
   wire [2:0] rdIdx = slotOf(s_axi_araddr);
   wire [2:0] rdKind = kindOf(s_axi_araddr);

   wire [63:0] cntAll [0:5];
   wire [63:0] matchAll [0:5];
   wire [7:0] ctrlAll [0:5];
   wire [5:0] evt;

   // ----------------------------------------
   // Timers
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < `NUM_TIMERS; i = i + 1) begin : timerGen
         reg [7:0] ctrl;
         reg [6:0] prescale;
         reg [63:0] cnt;
         reg [63:0] match;
         wire [63:0] widthMask = (i == `NUM_TIMERS - 1) ? `WIDE_MASK : `NARROW_MASK;
         wire sel = wrHit && (wrIdx == i);
         wire wrCtrl = sel && (wrKind == `KIND_CTRL);
         wire wrMatchLo = sel && (wrKind == `KIND_MATCH_LO);
         wire wrMatchHi = sel && (wrKind == `KIND_MATCH_HI);
         wire [31:0] ctrlMerged = applyStrobe({24'h0, ctrl}, s_axi_wdata, s_axi_wstrb);
         wire [7:0] newCtrl = ctrlMerged[7:0];
         wire running = ctrl[`CTRL_EN];
         wire [1:0] mode = ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
         wire [6:0] ratio = divRatio(ctrl[`CTRL_DIV_MSB:`CTRL_DIV_LSB]);
         wire srcTick = ctrl[`CTRL_CLKSEL] ? sysTick : rtcTick;
         wire divTick = running && srcTick && (prescale == ratio - 7'h01);
         wire hitMatch = divTick && (cnt == (match & widthMask)) && (mode != `MODE_WRAP_NO_IRQ);
         wire [63:0] cntInc = (cnt + 64'h1) & widthMask;

         assign cntAll[i] = cnt;
         assign matchAll[i] = match;
         assign ctrlAll[i] = ctrl;
         assign evt[i] = hitMatch;

         // Each timer has its own state only; no sharing between slices
         always @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               ctrl <= `CTRL_RESET;
               prescale <= 7'h00;
               cnt <= 64'h0;
               match <= 64'h0;
            end else begin
               if (wrCtrl) begin
                  ctrl <= newCtrl;
               end else if (hitMatch && mode == `MODE_ONE_SHOT) begin
                  ctrl[`CTRL_EN] <= 1'b0;
               end
               if (wrMatchLo) begin
                  match[31:0] <= applyStrobe(match[31:0], s_axi_wdata, s_axi_wstrb);
               end
               if (wrMatchHi) begin
                  match[63:32] <= applyStrobe(match[63:32], s_axi_wdata, s_axi_wstrb);
               end
               if ((wrMatchLo || wrMatchHi) && running) begin
                  cnt <= 64'h0;
                  prescale <= 7'h00;
               end else if (wrCtrl && newCtrl[`CTRL_EN] && !running) begin
                  cnt <= 64'h0;
                  prescale <= 7'h00;
               end else if (running && srcTick) begin
                  prescale <= (prescale >= ratio - 7'h01) ? 7'h00 : prescale + 7'h01;
                  if (divTick) begin
                     if (hitMatch && mode == `MODE_ONE_SHOT) begin
                        cnt <= cnt;
                     end else if (hitMatch && mode == `MODE_REPEAT) begin
                        cnt <= 64'h0;
                     end else begin
                        cnt <= cntInc;
                     end
                  end
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Interrupt status and mask
   // ----------------------------------------
   reg [5:0] status;
   reg [5:0] mask;
   reg [31:0] hiShadow;
   wire wrStatus = wrHit && (s_axi_awaddr == `ADDR_IRQ_STATUS);
   wire wrMask = wrHit && (s_axi_awaddr == `ADDR_IRQ_MASK);
   wire [5:0] clrBits = wrStatus ? (s_axi_wdata[5:0] & {6{s_axi_wstrb[0]}}) : 6'h00;
   // Set wins over a simultaneous write-one-to-clear
   wire [5:0] next_status = (status & ~clrBits) | evt;
   wire [31:0] maskMerged = applyStrobe({26'h0, mask}, s_axi_wdata, s_axi_wstrb);
   wire [5:0] next_mask = wrMask ? maskMerged[5:0] : mask;
   wire [5:0] next_mask6 = next_mask[5:0];

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         status <= 6'h00;
         mask <= 6'h00;
         timerIrq <= 6'h00;
         irq <= 1'b0;
         wakeReq <= 1'b0;
      end else begin
         status <= next_status;
         mask <= next_mask6;
         timerIrq <= next_status;
         irq <= |(next_status & next_mask6);
         wakeReq <= |(next_status & next_mask6);
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   reg [31:0] rdValue;
   always @* begin
      rdValue = 32'h0;
      if (s_axi_araddr == `ADDR_IRQ_STATUS) begin
         rdValue = {26'h0, status};
      end else if (s_axi_araddr == `ADDR_IRQ_MASK) begin
         rdValue = {26'h0, mask};
      end else if (rdIdx <= `LAST_TIMER) begin
         if (rdKind == `KIND_CTRL) begin
            rdValue = {24'h0, ctrlAll[rdIdx]};
         end else if (rdKind == `KIND_COUNT_LO) begin
            rdValue = cntAll[rdIdx][31:0];
         end else if (rdKind == `KIND_MATCH_LO) begin
            rdValue = matchAll[rdIdx][31:0];
         end else if (rdKind == `KIND_COUNT_HI) begin
            rdValue = hiShadow;
         end else if (rdKind == `KIND_MATCH_HI) begin
            rdValue = matchAll[rdIdx][63:32];
         end
      end
   end

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   // Ready pulses one cycle after both address and data are offered;
   // a single write and a single read are in flight at most.
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `RESP_OKAY;
         s_axi_rdata <= 32'h0;
         hiShadow <= 32'h0;
      end else begin
         if (s_axi_awready) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rdFire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= mapped(s_axi_araddr) ? rdValue : 32'h0;
            s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            // Upper half frozen for the following read; counter keeps running
            if (rdIdx == `WIDE_INDEX && rdKind == `KIND_COUNT_LO && isAligned(s_axi_araddr)) begin
               hiShadow <= cntAll[`WIDE_INDEX][63:32];
            end
         end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// ===== gpt_bank_regs.vh
`ifndef GPT_BANK_REGS_VH
`define GPT_BANK_REGS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define TIMER_STRIDE_LSB 5
`define ADDR_SLOT_MSB 7
`define ADDR_KIND_MSB 4
`define ADDR_KIND_LSB 2
`define ADDR_ALIGN_MSB 1
`define KIND_CTRL 3'h0
`define KIND_COUNT_LO 3'h1
`define KIND_MATCH_LO 3'h2
`define KIND_COUNT_HI 3'h3
`define KIND_MATCH_HI 3'h4
`define ADDR_IRQ_STATUS 8'hc0
`define ADDR_IRQ_MASK 8'hc4
`define NUM_TIMERS 6
`define WIDE_INDEX 3'h5
`define LAST_TIMER 3'h5

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_EN 0
`define CTRL_MODE_LSB 1
`define CTRL_MODE_MSB 2
`define CTRL_CLKSEL 3
`define CTRL_DIV_LSB 4
`define CTRL_DIV_MSB 7
`define CTRL_RESET 8'h00

`define MODE_ONE_SHOT 2'h0
`define MODE_REPEAT 2'h1
`define MODE_KEEP_GO 2'h2
`define MODE_WRAP_NO_IRQ 2'h3

// ----------------------------------------
// Divider codes
// ----------------------------------------
`define DIV_FINE_LAST 4'hc
`define DIV_CODE_16 4'hd
`define DIV_CODE_32 4'he
`define RATIO_16 7'h10
`define RATIO_32 7'h20
`define RATIO_64 7'h40

// ----------------------------------------
// Clock rates
// ----------------------------------------
`define MCLK_MHZ 7'd100
`define SYS_TICK_MHZ 7'd13

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define NARROW_MASK 64'h00000000ffffffff
`define WIDE_MASK 64'hffffffffffffffff

`endif

// ===== gpt_bank_props.sv
`timescale 1ns/100ps
module gpt_bank_props (
   input wire mclk,
   input wire arst_n,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [5:0] timerIrq,
   input wire irq,
   input wire wakeReq
);
   // ----
   // Bus and interrupt checks
   // ----
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence wrTake; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready; endsequence
   sequence wrDone; s_axi_awready && s_axi_wready ##1 s_axi_bvalid; endsequence
   sequence rdTake; s_axi_arvalid && !s_axi_rvalid && !s_axi_arready; endsequence
   sequence rdDone; s_axi_arready ##1 s_axi_rvalid; endsequence
   // Status or mask change lands one or two edges after the write handshake
   sequence wrSeen; $past(s_axi_awready) || $past(s_axi_awready, 2); endsequence
   write_answer_a:
      assert property (wrTake |=> wrDone) else $error("write answer late");
   read_answer_a:
      assert property (rdTake |=> rdDone) else $error("read answer late");
   bresp_holds_a:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
   rdata_holds_a:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
   wake_follows_a:
      assert property (wakeReq == irq) else $error("wake differs from irq");
   irq_pending_a:
      assert property (irq |-> |timerIrq) else $error("irq without pending");
   pending_holds_a:
      assert property (|($past(timerIrq) & ~timerIrq) |-> wrSeen) else $error("pending lost");
   irq_cause_a:
      assert property ($rose(irq) |-> |(timerIrq & ~$past(timerIrq)) || $past(s_axi_awready)
         || $past(s_axi_awready, 2)) else $error("irq from nowhere");
endmodule

bind general_purpose_timer_bank gpt_bank_props i_props (.*);

// ===== gpt_host.sv
`timescale 1ns/100ps
module gpt_host (
   input wire mclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   output logic s_axi_rready
);
   // ----
   // Bus master
   // ----
   logic [1:0] lastResp;
   // Every other call raises ready only once the answer stands
   logic lateReady;
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      lastResp = '0;
      lateReady = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      lateReady = ~lateReady;
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
      s_axi_bready <= !lateReady;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      lastResp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      lateReady = ~lateReady;
      {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
      s_axi_rready <= !lateReady;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Lower word first, so the upper word is the frozen copy
   task automatic rd64(input logic [7:0] b, output logic [63:0] v);
      logic [1:0] r;
      rd(b + 8'h04, v[31:0], r);
      rd(b + 8'h0c, v[63:32], r);
   endtask
endmodule

// ===== tb_general_purpose_timer_bank.sv
`timescale 1ns/100ps
`include "gpt_bank_regs.vh"
module tb_general_purpose_timer_bank;
   typedef struct packed {
      logic [2:0] t;
      logic [7:0] ctrl;
      logic [31:0] match;
      logic irqExp;
      logic [11:0] lo;
      logic [11:0] hi;
   } row_t;
   logic mclk, arst_n, rtcClk;
   wire [7:0] s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [1:0] s_axi_rresp, s_axi_bresp;
   wire [5:0] timerIrq;
   wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, wakeReq;
   int n_mismatch = 0;
   int n_checks = 0;
   int n;
   logic [31:0] d, d1;
   logic [63:0] v;
   logic [1:0] resp;
   logic [7:0] base;
   row_t r;
   // Timer, control, match, interrupt expected, cycle window
   row_t rows [6] = '{
      '{3'h0, 8'h09, 32'h3, 1'b1, 12'h00a, 12'h064},
      '{3'h1, 8'h1b, 32'h4, 1'b1, 12'h028, 12'h0c8},
      '{3'h2, 8'hdd, 32'h1, 1'b1, 12'h064, 12'h1f4},
      '{3'h3, 8'h0f, 32'h2, 1'b0, 12'h000, 12'h12c},
      '{3'h4, 8'h01, 32'h2, 1'b1, 12'h014, 12'h12c},
      '{3'h5, 8'hf5, 32'h1, 1'b1, 12'h7d0, 12'hc80}};

   general_purpose_timer_bank i_dut (.*, .s_axi_wstrb(4'hf));
   gpt_host i_host (.*);

   // ----
   // Checking and ending
   // ----
   task check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h, wanted %h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      $display("mismatches %0d, checks %0d", n_mismatch, n_checks);
      if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task settle;
      repeat (2) @(posedge mclk);
      #1;
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Slow clock off the fast grid, a stand-in for the real-time crystal
   initial begin
      rtcClk = 1'b0;
      forever #103 rtcClk = ~rtcClk;
   end
   initial begin
      repeat (40000) @(posedge mclk);
      n_mismatch++;
      end_of_test;
   end

   initial begin
      arst_n = 1'b0;
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      i_host.rd(8'h00, d, resp);
      check(d, 32'h0);
      i_host.rd(`ADDR_IRQ_MASK, d, resp);
      check(d, 32'h0);
      i_host.rd(8'hd0, d, resp);
      check({resp, d}, {`RESP_SLVERR, 32'h0});
      foreach (rows[i]) begin
         r = rows[i];
         base = {r.t, 5'h00};
         i_host.wr(base + 8'h08, r.match);
         i_host.wr(base, {24'h0, r.ctrl});
         n = 0;
         while (timerIrq[r.t] !== 1'b1 && n < r.hi) begin
            @(posedge mclk);
            #1;
            n++;
         end
         check(timerIrq[r.t], r.irqExp);
         check(n >= r.lo, 1'b1);
         check(wakeReq, 1'b0);
         if (r.ctrl[2]) repeat (2000) @(posedge mclk);
         i_host.rd(base, d, resp);
         check(d[7:0], r.ctrl[2:1] == `MODE_ONE_SHOT ? r.ctrl & 8'hfe : r.ctrl);
         i_host.rd64(base, v);
         case (r.ctrl[2:1])
            `MODE_ONE_SHOT: check(v[31:0], r.match);
            `MODE_REPEAT: check(v[31:0] <= r.match, 1'b1);
            default: check(v[31:0] > r.match, 1'b1);
         endcase
         check(v[63:32], 32'h0);
         if (r.irqExp) begin
            i_host.wr(`ADDR_IRQ_MASK, 32'h1 << r.t);
            settle;
            check({timerIrq[r.t], irq, wakeReq}, 3'b111);
            i_host.wr(base, 32'h0);
            i_host.wr(`ADDR_IRQ_STATUS, 32'h1 << r.t);
            settle;
            check({timerIrq[r.t], irq, wakeReq}, 3'b000);
            i_host.wr(`ADDR_IRQ_MASK, 32'h0);
         end
      end
      // Rewriting the match while counting must restart from zero
      i_host.wr(8'h08, 32'h3e8);
      i_host.wr(8'h00, 32'h0b);
      repeat (300) @(posedge mclk);
      i_host.rd(8'h04, d1, resp);
      i_host.wr(8'h08, 32'h3e8);
      i_host.rd(8'h04, d, resp);
      check(d < d1 && d1 > 32'h14, 1'b1);
      // Unmapped write is refused, a mapped one answers okay
      i_host.wr(8'hd4, 32'h1);
      check(i_host.lastResp, `RESP_SLVERR);
      i_host.wr(`ADDR_IRQ_MASK, 32'h3f);
      check(i_host.lastResp, `RESP_OKAY);
      // Reset in mid-run clears a running timer and the mask
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      #1;
      check({s_axi_bvalid, s_axi_rvalid, timerIrq, irq, wakeReq}, 10'h000);
      i_host.rd(8'h00, d, resp);
      check(d, 32'h0);
      i_host.rd(`ADDR_IRQ_MASK, d, resp);
      check(d, 32'h0);
      end_of_test;
   end
endmodule
